// >>> src/core_pkg.sv
// constants, types and tables for the core register and interrupt block
// assumes one 200 MHz clock and a synchronous active-low reset
package core_pkg;

    // special register addresses
    localparam logic [7:0] SP_ADDR  = 8'h81;
    localparam logic [7:0] DPL_ADDR = 8'h82;
    localparam logic [7:0] DPH_ADDR = 8'h83;
    localparam logic [7:0] PSW_ADDR = 8'hd0;
    localparam logic [7:0] ACC_ADDR = 8'he0;
    localparam logic [7:0] B_ADDR   = 8'hf0;

    // reset values
    localparam logic [7:0] SP_RST   = 8'h07;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // status word bit positions
    localparam int CY_BIT  = 7;
    localparam int AC_BIT  = 6;
    localparam int F0_BIT  = 5;
    localparam int RS1_BIT = 4;
    localparam int RS0_BIT = 3;
    localparam int OV_BIT  = 2;
    localparam int F1_BIT  = 1;
    localparam int PAR_BIT = 0;

    // interrupt sources, arbitration rank = index
    localparam int NUM_SRC = 20;
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
        16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h004b,
        16'h0053, 16'h005b, 16'h0063, 16'h0073, 16'h007b,
        16'h0083, 16'h0093, 16'h008b, 16'h009b, 16'h00a3};
    // sources whose flag hardware clears on vectoring
    localparam logic [NUM_SRC-1:0] HW_CLR_MASK = 20'h4000f;

    // arithmetic operation kinds
    typedef enum logic [5:0] {
        ALU_ADD   = 6'b000001,
        ALU_ADDC  = 6'b000010,
        ALU_SUBB  = 6'b000100,
        ALU_MUL   = 6'b001000,
        ALU_DIV   = 6'b010000,
        ALU_OTHER = 6'b100000
    } alu_kind_t;

    // in-service level tracking
    typedef enum logic [3:0] {
        SVC_IDLE  = 4'b0001,
        SVC_LO    = 4'b0010,
        SVC_HI    = 4'b0100,
        SVC_HI_LO = 4'b1000
    } svc_state_t;

    // one arithmetic step from the core
    typedef struct packed {
        logic       valid;
        alu_kind_t  kind;
        logic [7:0] operand;
    } alu_op_t;

    // special register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// >>> src/irq_pick.sv
// fixed-rank picker: high level first, then lowest index
// assumes request and level vectors from the same clock domain
`timescale 1ns/1ps
module irq_pick (
    // requests
    input  wire logic [19:0] req,
    input  wire logic [19:0] hi,
    // winner
    output logic             found,
    output logic [4:0]       idx,
    output logic             is_hi
);
    // scan downward so the lowest index wins
    always_comb begin
        found = 1'b0;
        idx   = 5'h00;
        is_hi = 1'b0;
        for (int i = 19; i >= 0; i--) begin
            if (req[i] && !hi[i] && !is_hi) begin
                found = 1'b1;
                idx   = 5'(i);
            end
        end
        for (int i = 19; i >= 0; i--) begin
            if (req[i] && hi[i]) begin
                found = 1'b1;
                idx   = 5'(i);
                is_hi = 1'b1;
            end
        end
    end
endmodule // irq_pick

// >>> src/core_regs_irq.sv
// core special registers and interrupt dispatch
// assumes core, peripherals and enables all on ref_clk
`timescale 1ns/1ps
module core_regs_irq (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // special register access
    input  wire core_pkg::sfr_req_t   sfr_req,
    output logic [7:0]                sfr_rdata,
    output logic                      sfr_hit,
    // core sequencing
    input  wire core_pkg::alu_op_t    alu_op,
    input  wire logic                 push_stb,
    input  wire logic                 pop_stb,
    input  wire logic                 instr_done,
    input  wire logic                 next_single,
    input  wire logic                 irq_return_instr_done,
    // interrupt control levels
    input  wire logic                 global_irq_gate,
    input  wire logic [19:0]          src_enable,
    input  wire logic [19:0]          src_hi_prio,
    // pending flag sources
    input  wire logic [19:0]          pend_event,
    input  wire logic [19:0]          pend_sw_set,
    input  wire logic [19:0]          pend_sw_clr,
    // register views
    output logic [7:0]                stack_pointer,
    output logic [15:0]               indirect_pointer16,
    output logic [7:0]                status_word,
    output logic [7:0]                acc_out,
    output logic [7:0]                b_out,
    output logic [4:0]                bank_base,
    // interrupt dispatch
    output logic [19:0]               pending_flags,
    output logic                      vec_req,
    output logic [15:0]               vec_addr,
    output logic [4:0]                vec_src,
    output logic                      in_service_hi
);

    ////////////////////////////////////////////////////////////
    // functions

    // odd parity of a byte
    function automatic logic odd_par(input logic [7:0] v);
        return ^v;
    endfunction

    // bank base address from status word
    function automatic logic [4:0] bank_of(input logic [7:0] p);
        return {p[core_pkg::RS1_BIT], p[core_pkg::RS0_BIT], 3'b000};
    endfunction

    ////////////////////////////////////////////////////////////
    // registers

    logic [7:0] sp_reg;      // stack pointer
    logic [7:0] dpl_reg;     // pointer low byte
    logic [7:0] dph_reg;     // pointer high byte
    logic [7:0] psw_reg;     // status word, parity included
    logic [7:0] acc_reg;     // primary accumulator
    logic [7:0] b_reg;       // secondary accumulator
    logic [7:0] acc_next;    // accumulator next value
    logic [7:0] b_next;      // secondary next value
    logic [7:0] psw_next;    // status word next value
    logic [19:0] pend_reg;   // pending flags
    logic [19:0] pend_next;  // pending next value

    // write strobes per register
    logic wr_sp;
    logic wr_dpl;
    logic wr_dph;
    logic wr_psw;
    logic wr_acc;
    logic wr_b;

    assign wr_sp  = sfr_req.wr && (sfr_req.addr == core_pkg::SP_ADDR);
    assign wr_dpl = sfr_req.wr && (sfr_req.addr == core_pkg::DPL_ADDR);
    assign wr_dph = sfr_req.wr && (sfr_req.addr == core_pkg::DPH_ADDR);
    assign wr_psw = sfr_req.wr && (sfr_req.addr == core_pkg::PSW_ADDR);
    assign wr_acc = sfr_req.wr && (sfr_req.addr == core_pkg::ACC_ADDR);
    assign wr_b   = sfr_req.wr && (sfr_req.addr == core_pkg::B_ADDR);

    ////////////////////////////////////////////////////////////
    // stack pointer

    // write wins; push pre-increments; pop post-decrements
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sp_reg <= core_pkg::SP_RST;
        end else if (wr_sp) begin
            sp_reg <= sfr_req.wdata;
        end else if (push_stb) begin
            sp_reg <= sp_reg + 8'h01;
        end else if (pop_stb) begin
            sp_reg <= sp_reg - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    // data pointer

    // two plain bytes joined into one pointer
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dpl_reg <= core_pkg::BYTE_RST;
            dph_reg <= core_pkg::BYTE_RST;
        end else begin
            if (wr_dpl) begin
                dpl_reg <= sfr_req.wdata;
            end
            if (wr_dph) begin
                dph_reg <= sfr_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // arithmetic flags and results

    logic [8:0]  sum9;   // add with carry out
    logic [4:0]  sum5;   // low nibble add
    logic [8:0]  dif9;   // subtract with borrow
    logic [4:0]  dif5;   // low nibble subtract
    logic [15:0] prod;   // multiply result
    logic        cin;    // carry in for addc/subb

    // datapath feeding the flag update
    always_comb begin
        cin  = (alu_op.kind == core_pkg::ALU_ADD) ? 1'b0
             : psw_reg[core_pkg::CY_BIT];
        sum9 = {1'b0, acc_reg} + {1'b0, alu_op.operand} + {8'h00, cin};
        sum5 = {1'b0, acc_reg[3:0]} + {1'b0, alu_op.operand[3:0]}
             + {4'h0, cin};
        dif9 = {1'b0, acc_reg} - {1'b0, alu_op.operand} - {8'h00, cin};
        dif5 = {1'b0, acc_reg[3:0]} - {1'b0, alu_op.operand[3:0]}
             - {4'h0, cin};
        prod = acc_reg * b_reg;
    end

    // next accumulator, secondary and status word
    always_comb begin
        acc_next = wr_acc ? sfr_req.wdata : acc_reg;
        b_next   = wr_b ? sfr_req.wdata : b_reg;
        psw_next = wr_psw ? sfr_req.wdata : psw_reg;
        if (alu_op.valid) begin
            case (alu_op.kind)
                core_pkg::ALU_ADD, core_pkg::ALU_ADDC: begin
                    acc_next = sum9[7:0];
                    psw_next[core_pkg::CY_BIT] = sum9[8];
                    psw_next[core_pkg::AC_BIT] = sum5[4];
                    psw_next[core_pkg::OV_BIT] =
                        (acc_reg[7] == alu_op.operand[7]) &&
                        (sum9[7] != acc_reg[7]);
                end
                core_pkg::ALU_SUBB: begin
                    acc_next = dif9[7:0];
                    psw_next[core_pkg::CY_BIT] = dif9[8];
                    psw_next[core_pkg::AC_BIT] = dif5[4];
                    psw_next[core_pkg::OV_BIT] =
                        (acc_reg[7] != alu_op.operand[7]) &&
                        (dif9[7] != acc_reg[7]);
                end
                core_pkg::ALU_MUL: begin
                    acc_next = prod[7:0];
                    b_next   = prod[15:8];
                    psw_next[core_pkg::CY_BIT] = 1'b0;
                    psw_next[core_pkg::AC_BIT] = 1'b0;
                    psw_next[core_pkg::OV_BIT] = |prod[15:8];
                end
                core_pkg::ALU_DIV: begin
                    psw_next[core_pkg::CY_BIT] = 1'b0;
                    psw_next[core_pkg::AC_BIT] = 1'b0;
                    psw_next[core_pkg::OV_BIT] = (b_reg == 8'h00);
                    if (b_reg != 8'h00) begin
                        acc_next = acc_reg / b_reg;
                        b_next   = acc_reg % b_reg;
                    end
                end
                default: begin
                    // other arithmetic: clear carries only
                    psw_next[core_pkg::CY_BIT] = 1'b0;
                    psw_next[core_pkg::AC_BIT] = 1'b0;
                end
            endcase
        end
        // parity is hardware owned, never stored from software
        psw_next[core_pkg::PAR_BIT] = odd_par(acc_next);
    end

    // accumulator, secondary and status word storage
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            acc_reg <= core_pkg::BYTE_RST;
            b_reg   <= core_pkg::BYTE_RST;
            psw_reg <= core_pkg::BYTE_RST;
        end else begin
            acc_reg <= acc_next;
            b_reg   <= b_next;
            psw_reg <= psw_next;
        end
    end

    ////////////////////////////////////////////////////////////
    // register views

    // outputs all registered from next values
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_word <= core_pkg::BYTE_RST;
            acc_out     <= core_pkg::BYTE_RST;
            b_out       <= core_pkg::BYTE_RST;
            bank_base   <= 5'h00;
        end else begin
            status_word <= psw_next;
            acc_out     <= acc_next;
            b_out       <= b_next;
            bank_base   <= bank_of(psw_next);
        end
    end

    // pointer and stack views track their registers
    assign stack_pointer      = sp_reg;
    assign indirect_pointer16 = {dph_reg, dpl_reg};

    ////////////////////////////////////////////////////////////
    // register read port

    // one-cycle registered read, unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_hit   <= sfr_req.rd;
            sfr_rdata <= 8'h00;
            if (sfr_req.rd) begin
                case (sfr_req.addr)
                    core_pkg::SP_ADDR:  sfr_rdata <= sp_reg;
                    core_pkg::DPL_ADDR: sfr_rdata <= dpl_reg;
                    core_pkg::DPH_ADDR: sfr_rdata <= dph_reg;
                    core_pkg::PSW_ADDR: sfr_rdata <= psw_reg;
                    core_pkg::ACC_ADDR: sfr_rdata <= acc_reg;
                    core_pkg::B_ADDR:   sfr_rdata <= b_reg;
                    default:            sfr_hit   <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // interrupt arbitration

    core_pkg::svc_state_t svc_reg;  // in-service level
    logic [19:0] eligible;          // enabled and pending
    logic [19:0] allowed;           // after level filter
    logic        pick_found;        // a winner exists
    logic [4:0]  pick_idx;          // winning source
    logic        pick_hi;           // winner is high level
    logic        gate_q;            // gate one cycle ago
    logic        late_pend;         // request caught at gate clear
    logic [4:0]  late_idx;          // that request's source
    logic        late_hi;           // and its level
    logic        take;              // vector this cycle
    logic [4:0]  take_idx;          // source vectored
    logic        take_hi;           // level vectored

    // gate and enables mask pending flags
    assign eligible = pend_reg & src_enable
                    & {20{global_irq_gate}};

    // high routine blocks all; low routine admits high only
    always_comb begin
        case (svc_reg)
            core_pkg::SVC_IDLE: allowed = eligible;
            core_pkg::SVC_LO:   allowed = eligible & src_hi_prio;
            default:            allowed = 20'h00000;
        endcase
    end

    // ranked pick among 20 sources
    irq_pick u_pick (
        .req   (allowed),
        .hi    (src_hi_prio),
        .found (pick_found),
        .idx   (pick_idx),
        .is_hi (pick_hi)
    );

    // no vector on the return's own completion
    always_comb begin
        take     = 1'b0;
        take_idx = pick_idx;
        take_hi  = pick_hi;
        if (instr_done && !irq_return_instr_done) begin
            if (pick_found) begin
                take = 1'b1;
            end else if (late_pend && next_single) begin
                take     = 1'b1;
                take_idx = late_idx;
                take_hi  = late_hi;
            end
        end
    end

    // catch a request posted as the gate falls
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gate_q    <= 1'b0;
            late_pend <= 1'b0;
            late_idx  <= 5'h00;
            late_hi   <= 1'b0;
        end else begin
            gate_q <= global_irq_gate;
            if (instr_done) begin
                late_pend <= 1'b0;
            end else if (gate_q && !global_irq_gate) begin
                // window is one instruction long
                late_pend <= |(pend_reg & src_enable & allowed_mask(svc_reg));
                late_idx  <= late_pick(pend_reg & src_enable);
                late_hi   <= src_hi_prio[late_pick(pend_reg & src_enable)];
            end
        end
    end

    // level filter for the late window
    function automatic logic [19:0] allowed_mask(input core_pkg::svc_state_t s);
        case (s)
            core_pkg::SVC_IDLE: return 20'hfffff;
            core_pkg::SVC_LO:   return src_hi_prio;
            default:            return 20'h00000;
        endcase
    endfunction

    // lowest index set, used for the late window
    function automatic logic [4:0] late_pick(input logic [19:0] r);
        logic [4:0] k;
        k = 5'h00;
        for (int i = 19; i >= 0; i--) begin
            if (r[i]) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////
    // in-service level tracking

    // enter on vector, leave on return; high view moves with the state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            svc_reg       <= core_pkg::SVC_IDLE;
            in_service_hi <= 1'b0;
        end else if (take) begin
            case (svc_reg)
                core_pkg::SVC_IDLE: begin
                    svc_reg       <= take_hi ? core_pkg::SVC_HI
                                             : core_pkg::SVC_LO;
                    in_service_hi <= take_hi;
                end
                core_pkg::SVC_LO: begin
                    svc_reg       <= core_pkg::SVC_HI_LO;
                    in_service_hi <= 1'b1;
                end
                default: svc_reg <= svc_reg;
            endcase
        end else if (irq_return_instr_done) begin
            // any return leaves no high routine running
            in_service_hi <= 1'b0;
            case (svc_reg)
                core_pkg::SVC_HI_LO: svc_reg <= core_pkg::SVC_LO;
                default:             svc_reg <= core_pkg::SVC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // pending flags

    // set beats every clear; hardware clears HW_CLR_MASK sources on vector
    always_comb begin
        pend_next = pend_reg & ~pend_sw_clr;
        if (take && core_pkg::HW_CLR_MASK[take_idx]) begin
            pend_next[take_idx] = 1'b0;
        end
        pend_next = pend_next | pend_event | pend_sw_set;
    end

    // flag storage
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pend_reg <= 20'h00000;
        end else begin
            pend_reg <= pend_next;
        end
    end

    assign pending_flags = pend_reg;

    ////////////////////////////////////////////////////////////
    // vector outputs

    // one-cycle call request with its address
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            vec_req       <= 1'b0;
            vec_addr      <= 16'h0000;
            vec_src       <= 5'h00;
        end else begin
            vec_req <= take;
            if (take) begin
                vec_addr <= core_pkg::VEC_TABLE[take_idx];
                vec_src  <= take_idx;
            end
        end
    end

endmodule // core_regs_irq

// >>> tb/core_regs_irq_chk.sv
// checker for the core register and interrupt block
// assumes it is bound onto core_regs_irq, one clock domain
`timescale 1ns/1ps
module core_regs_irq_chk (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst_b,
    // core sequencing seen at the inputs
    input wire core_pkg::sfr_req_t sfr_req,
    input wire logic               push_stb,
    input wire logic               pop_stb,
    input wire logic               instr_done,
    input wire logic               irq_return_instr_done,
    input wire logic [19:0]        src_enable,
    input wire logic [19:0]        pend_event,
    // outputs under watch
    input wire logic [7:0]         stack_pointer,
    input wire logic [7:0]         status_word,
    input wire logic [7:0]         acc_out,
    input wire logic [4:0]         bank_base,
    input wire logic [19:0]        pending_flags,
    input wire logic               vec_req,
    input wire logic [15:0]        vec_addr,
    input wire logic [4:0]         vec_src,
    input wire logic               in_service_hi
);
    // one domain, reset disables every check
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_sp_reset_val: assert property ($rose(rst_b) |-> stack_pointer == core_pkg::SP_RST)
        else $error("stack pointer off after reset");
    chk_sp_push_inc: assert property (push_stb && !pop_stb && !sfr_req.wr |=>
        stack_pointer == $past(stack_pointer) + 8'h01) else $error("push did not step");
    chk_parity_acc: assert property (status_word[0] == ^acc_out)
        else $error("parity bit wrong");
    chk_bank_base: assert property (bank_base == {status_word[4:3], 3'b000})
        else $error("bank base wrong");
    chk_pend_set: assert property (|pend_event |=>
        (pending_flags & $past(pend_event)) == $past(pend_event)) else $error("flag not set");
    chk_vec_cause: assert property (vec_req |-> $past(instr_done) && !$past(irq_return_instr_done) &&
        (($past(src_enable) >> vec_src) & 20'h00001) != 20'h0) else $error("vector w/o cause");
    chk_vec_table: assert property (vec_req |-> vec_addr == core_pkg::VEC_TABLE[vec_src])
        else $error("vector address wrong");
    chk_hw_clear: assert property (vec_req && core_pkg::HW_CLR_MASK[vec_src] |->
        !pending_flags[vec_src]) else $error("flag not cleared on vector");
    chk_hi_no_preempt: assert property (in_service_hi && instr_done && !irq_return_instr_done |=>
        !vec_req) else $error("high routine preempted");
endmodule // core_regs_irq_chk

bind core_regs_irq core_regs_irq_chk u_chk (.ref_clk, .rst_b, .sfr_req, .push_stb, .pop_stb,
    .instr_done, .irq_return_instr_done, .src_enable, .pend_event, .stack_pointer, .status_word, .acc_out,
    .bank_base, .pending_flags, .vec_req, .vec_addr, .vec_src, .in_service_hi);

// >>> tb/periph_model.sv
// peripheral side: raises one condition pulse on a chosen source
// assumes fire and sel change just after a falling clock edge
`timescale 1ns/1ps
module periph_model (
    // command from the bench
    input wire logic        fire,
    input wire logic [4:0]  sel,
    // condition pulses, one per source
    output logic [19:0]     pend_event
);
    // one of twenty sources, pulse lasts while fire is high
    always_comb pend_event = fire ? (20'h00001 << sel) : 20'h00000;
endmodule // periph_model

// >>> tb/tb_top.sv
// testbench for the core register and interrupt block
// assumes inputs driven at the falling edge of a 200 MHz clock
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rst_b, push_stb, pop_stb, instr_done, next_single, irq_return_instr_done, gate, fire;
    core_pkg::sfr_req_t sfr_req;
    core_pkg::alu_op_t  alu_op;
    logic [19:0] src_enable, src_hi_prio, pend_event, sw_set, sw_clr, pending_flags;
    logic [7:0]  sfr_rdata, stack_pointer, status_word, acc_out, b_out;
    logic [15:0] indirect_pointer16, vec_addr;
    logic [4:0]  sel, bank_base, vec_src;
    logic        sfr_hit, vec_req, in_service_hi;
    int          error_cnt, cmp_count;
    logic [7:0]  addrs [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
    periph_model u_per (.fire, .sel, .pend_event);
    core_regs_irq dut (.ref_clk, .rst_b, .sfr_req, .sfr_rdata, .sfr_hit, .alu_op, .push_stb,
        .pop_stb, .instr_done, .next_single, .irq_return_instr_done, .global_irq_gate(gate), .src_enable,
        .src_hi_prio, .pend_event, .pend_sw_set(sw_set), .pend_sw_clr(sw_clr), .stack_pointer,
        .indirect_pointer16, .status_word, .acc_out, .b_out, .bank_base, .pending_flags,
        .vec_req, .vec_addr, .vec_src, .in_service_hi);
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk) sfr_req = '0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        sfr_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk) sfr_req = '0;
        chk({sfr_hit, sfr_rdata}, {h, e});
    endtask
    // one arithmetic step after presetting status, acc and b
    task automatic alu_run(input core_pkg::alu_kind_t k, input logic [7:0] p, a, b, ea, eb, m, ep);
        reg_wr(core_pkg::PSW_ADDR, p);
        reg_wr(core_pkg::ACC_ADDR, a);
        reg_wr(core_pkg::B_ADDR, b);
        alu_op = '{1'b1, k, b};
        @(negedge ref_clk) alu_op = '0;
        chk({acc_out, b_out}, {ea, eb});
        chk(status_word & m, ep);
    endtask
    // instruction end, optionally a return, then check vectoring
    task automatic step(input logic rt, input logic ev, input logic [4:0] s);
        instr_done = 1'b1;
        irq_return_instr_done = rt;
        @(negedge ref_clk) {instr_done, irq_return_instr_done} = 2'b00;
        chk({vec_req, ev ? vec_src : 5'h00}, {ev, s});
    endtask
    task automatic raise(input logic [4:0] s);
        {fire, sel} = {1'b1, s};
        @(negedge ref_clk) fire = 1'b0;
    endtask
    task automatic sw(input logic [19:0] s, input logic [19:0] c);
        {sw_set, sw_clr} = {s, c};
        @(negedge ref_clk) {sw_set, sw_clr} = '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000 error_cnt++;
        stop_test();
    end
    initial begin
        {rst_b, push_stb, pop_stb, instr_done, next_single, irq_return_instr_done, gate, fire} = '0;
        {sfr_req, alu_op, sel, sw_set, sw_clr} = '0;
        {src_enable, src_hi_prio, error_cnt, cmp_count} = {20'h0004e, 20'h0000c, 64'h0};
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 6; i++) reg_rd(addrs[i], i == 0 ? 8'h07 : 8'h00, 1'b1);
        reg_rd(8'h84, 8'h00, 1'b0);
        reg_wr(core_pkg::DPL_ADDR, 8'h34);
        reg_wr(core_pkg::DPH_ADDR, 8'h12);
        chk(indirect_pointer16, 16'h1234);
        push_stb = 1'b1;
        repeat (2) @(negedge ref_clk);
        {push_stb, pop_stb} = 2'b01;
        @(negedge ref_clk) pop_stb = 1'b0;
        chk(stack_pointer, 8'h08);
        alu_run(core_pkg::ALU_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h01, 8'hc5, 8'h45);
        alu_run(core_pkg::ALU_ADD, 8'h00, 8'hff, 8'h01, 8'h00, 8'h01, 8'hc5, 8'hc0);
        alu_run(core_pkg::ALU_ADDC, 8'h80, 8'h10, 8'h05, 8'h16, 8'h05, 8'hc5, 8'h01);
        alu_run(core_pkg::ALU_SUBB, 8'h00, 8'h00, 8'h01, 8'hff, 8'h01, 8'hc5, 8'hc0);
        alu_run(core_pkg::ALU_SUBB, 8'h80, 8'h80, 8'h00, 8'h7f, 8'h00, 8'hc5, 8'h45);
        alu_run(core_pkg::ALU_MUL, 8'h00, 8'h10, 8'h20, 8'h00, 8'h02, 8'h05, 8'h04);
        alu_run(core_pkg::ALU_MUL, 8'h04, 8'h03, 8'h04, 8'h0c, 8'h00, 8'h05, 8'h00);
        alu_run(core_pkg::ALU_DIV, 8'h00, 8'h05, 8'h00, 8'h05, 8'h00, 8'h04, 8'h04);
        alu_run(core_pkg::ALU_OTHER, 8'hc4, 8'h33, 8'h00, 8'h33, 8'h00, 8'hc4, 8'h04);
        for (int i = 0; i < 4; i++) begin
            reg_wr(core_pkg::PSW_ADDR, {3'b001, i[1:0], 3'b010});
            chk(bank_base, {i[1:0], 3'b000});
            chk(status_word & 8'h3a, {3'b001, i[1:0], 3'b010});
        end
        gate = 1'b1;
        raise(5'd1);
        chk(pending_flags[1], 1'b1);
        step(1'b0, 1'b1, 5'd1);
        chk(pending_flags[1], 1'b0);
        step(1'b1, 1'b0, 5'd0);
        raise(5'd5);
        step(1'b0, 1'b0, 5'd0);
        sw(20'h0, 20'h00020);
        gate = 1'b0;
        raise(5'd6);
        step(1'b0, 1'b0, 5'd0);
        gate = 1'b1;
        step(1'b0, 1'b1, 5'd6);
        chk(pending_flags[6], 1'b1);
        raise(5'd2);
        step(1'b0, 1'b1, 5'd2);
        chk(in_service_hi, 1'b1);
        raise(5'd3);
        step(1'b0, 1'b0, 5'd0);
        step(1'b1, 1'b0, 5'd0);
        step(1'b0, 1'b1, 5'd3);
        step(1'b1, 1'b0, 5'd0);
        step(1'b1, 1'b0, 5'd0);
        step(1'b0, 1'b1, 5'd6);
        sw(20'h0, 20'h00040);
        step(1'b1, 1'b0, 5'd0);
        sw(20'h00002, 20'h0);
        step(1'b0, 1'b1, 5'd1);
        step(1'b1, 1'b0, 5'd0);
        raise(5'd6);
        gate = 1'b0;
        @(negedge ref_clk);
        step(1'b0, 1'b0, 5'd0);
        gate = 1'b1;
        @(negedge ref_clk) gate = 1'b0;
        @(negedge ref_clk) next_single = 1'b1;
        step(1'b0, 1'b1, 5'd6);
        next_single = 1'b0;
        sw(20'h0, 20'h00040);
        step(1'b1, 1'b0, 5'd0);
        stop_test();
    end
endmodule // tb_top
